//--- hdl/clock_manager_map.svh
// Overview of operation
// - Output clocks are delayed by phase setting over 256 times the reference period.
// - The phase setting accepts any signed value from -255 to +255 at any frequency.
// - The applied shift is limited to what the delay line can reach.
// - Reachable shift is the full line span in fixed mode and half of it in variable mode.
// - In variable mode the zero-skew point sits at the middle of the line span, tap SPAN/2.
// - In fixed mode the phase setting is frozen once locked; either sign is reachable.
// - High-frequency mode stops the doubled and quarter-phase outputs.
// - Bit 1 of the control register picks low- or high-frequency operation.
`ifndef CLOCK_MANAGER_MAP_SVH
`define CLOCK_MANAGER_MAP_SVH
`define CM_ADDR_CTRL 8'h00
`define CM_ADDR_PHASE 8'h04
`define CM_ADDR_STATUS 8'h08
`define CM_CTRL_VAR_BIT 0
`define CM_CTRL_HF_BIT 1
`define CM_CTRL_EN_BIT 2
`define CM_PHASE_DEN_SHIFT 8
`define CM_PHASE_MAX 255
`define CM_PHASE_RESET 9'sh000
`define CM_CTRL_RESET 3'h0
`endif

//--- hdl/clock_manager_phase_shift.sv
`timescale 1ns/10ps
`include "clock_manager_map.svh"
module clock_manager_phase_shift
   import clock_manager_pkg::*;
#(
   parameter int LINE = 128,
   parameter int SPAN = 64,
   parameter int FX_DIV = 3
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_input_reference_clock,
   input wire logic i_feedback_clock_input,
   output logic o_zero_degree_output,
   output logic o_half_cycle_output,
   output logic o_quarter_cycle_output,
   output logic o_three_quarter_cycle_output,
   output logic o_doubled_output,
   output logic o_doubled_inverted_output,
   output logic o_divided_output,
   output logic o_synthesized_output,
   output logic o_synthesized_inverted_output
);
   localparam int MID = SPAN / 2;

   // elaboration check
   if (LINE != 128 || SPAN < 2 || SPAN > 127 || FX_DIV < 1 || FX_DIV > 15) begin : g_bad
      $error("clock_manager_phase_shift: unsupported parameters");
   end

   typedef struct packed {
      logic [1:0] ref_sync;
      logic [1:0] fb_sync;
      logic ref_prev;
      logic [LINE-1:0] line;
      logic [7:0] cnt;
      logic [7:0] period;
      lock_e st;
      logic mode_var;
      logic freq_high;
      logic en;
      logic signed [8:0] phase;
      logic signed [9:0] shift;
      logic sat;
      logic [6:0] tap;
      logic zero;
      logic quarter;
      logic three;
      logic div;
      logic fx;
      logic [3:0] fx_cnt;
      // output copies, so that every pin leaves a flop
      logic half;
      logic quarter_out;
      logic three_out;
      logic dbl;
      logic dbl_inv;
      logic fx_inv;
      logic ready;
      logic slverr;
      logic [31:0] prdata;
   } state_s;

   state_s s_q, s_d;

   // clamp a signed tap index into the delay line
   function automatic logic [6:0] clamp_tap(input logic signed [10:0] v);
      if (v < 0) begin
         return 7'h00;
      end else if (v > 11'sd127) begin
         return 7'h7f;
      end
      return v[6:0];
   endfunction

   // saturate a shift to +-lim instead of wrapping
   function automatic logic signed [9:0] sat_shift(input logic signed [9:0] v,
                                                   input logic signed [9:0] lim);
      if (v > lim) begin
         return lim;
      end else if (v < -lim) begin
         return -lim;
      end
      return v;
   endfunction

   // saturate a written word into the phase range
   function automatic logic signed [8:0] sat_phase(input logic signed [31:0] w);
      if (w > `CM_PHASE_MAX) begin
         return 9'sd255;
      end else if (w < -`CM_PHASE_MAX) begin
         return -9'sd255;
      end
      return w[8:0];
   endfunction

   logic rise;
   logic signed [17:0] prod;
   logic signed [9:0] raw;
   logic signed [9:0] lim;
   logic signed [10:0] base;
   logic [7:0] per_q4;
   logic [7:0] per_3q4;
   logic setup;
   logic access;
   logic hit;
   logic zero_rise;

   // next-state logic for the whole block
   always_comb begin
      s_d = s_q;
      s_d.ref_sync = {s_q.ref_sync[0], i_input_reference_clock};
      s_d.fb_sync = {s_q.fb_sync[0], i_feedback_clock_input};
      s_d.ref_prev = s_q.ref_sync[1];
      s_d.line = {s_q.line[LINE-2:0], s_q.ref_sync[1]};
      rise = s_q.ref_sync[1] & ~s_q.ref_prev;

      // period of the reference in system cycles
      if (rise) begin
         s_d.cnt = 8'h01;
         s_d.period = s_q.cnt;
      end else if (s_q.cnt != 8'hff) begin
         s_d.cnt = s_q.cnt + 8'h01;
      end

      // lock sequencing
      unique case (s_q.st)
         ST_IDLE: begin
            if (s_q.en) begin
               s_d.st = ST_MEAS;
            end
         end
         ST_MEAS: begin
            if (!s_q.en) begin
               s_d.st = ST_IDLE;
            end else if (rise && s_q.period != 8'h00) begin
               s_d.st = ST_LOCK;
            end
         end
         ST_LOCK: begin
            if (!s_q.en) begin
               s_d.st = ST_IDLE;
            end
         end
      endcase

      // shift = phase/256 * period, limited by the line span
      prod = s_q.phase * $signed({1'b0, s_q.period});
      raw = prod[17:8];
      lim = s_q.mode_var ? 10'(MID) : 10'(SPAN);
      s_d.shift = sat_shift(raw, lim);
      s_d.sat = (raw > lim) || (raw < -lim);
      if (s_q.mode_var) begin
         base = 11'(MID) + 11'(s_d.shift);
      end else if (s_d.shift >= 0) begin
         base = 11'(s_d.shift);
      end else begin
         base = $signed({3'b000, s_q.period}) + 11'(s_d.shift);
      end
      s_d.tap = clamp_tap(base);
      per_q4 = {2'b00, s_q.period[7:2]};
      per_3q4 = per_q4 + {1'b0, s_q.period[7:1]};

      // tapped clock outputs, gated until locked
      if (s_q.st == ST_LOCK) begin
         s_d.zero = s_q.line[s_q.tap];
         s_d.quarter = s_q.line[clamp_tap(11'(s_q.tap) + 11'(per_q4))];
         s_d.three = s_q.line[clamp_tap(11'(s_q.tap) + 11'(per_3q4))];
      end else begin
         s_d.zero = 1'b0;
         s_d.quarter = 1'b0;
         s_d.three = 1'b0;
      end
      zero_rise = s_d.zero & ~s_q.zero;
      if (s_q.st != ST_LOCK) begin
         s_d.div = 1'b0;
         s_d.fx = 1'b0;
         s_d.fx_cnt = 4'h0;
      end else if (zero_rise) begin
         s_d.div = ~s_q.div;
         if (s_q.fx_cnt == 4'(FX_DIV - 1)) begin
            s_d.fx_cnt = 4'h0;
            s_d.fx = ~s_q.fx;
         end else begin
            s_d.fx_cnt = s_q.fx_cnt + 4'h1;
         end
      end

      // apb slave: answer prepared in setup, given in access
      setup = i_psel & ~i_penable;
      access = i_psel & i_penable & s_q.ready;
      hit = (i_paddr == `CM_ADDR_CTRL) || (i_paddr == `CM_ADDR_PHASE)
         || (i_paddr == `CM_ADDR_STATUS);
      s_d.ready = setup;
      if (setup) begin
         s_d.slverr = ~hit;
         s_d.prdata = 32'h0;
         if (!i_pwrite) begin
            unique case (i_paddr)
               `CM_ADDR_CTRL: s_d.prdata = {29'h0, s_q.en, s_q.freq_high, s_q.mode_var};
               `CM_ADDR_PHASE: s_d.prdata = 32'(s_q.phase);
               `CM_ADDR_STATUS: s_d.prdata = {8'h00, 1'b0, s_q.tap, s_q.period,
                  5'h00, s_q.fb_sync[1], s_q.sat, s_q.st == ST_LOCK};
               default: s_d.prdata = 32'h0;
            endcase
         end
      end else if (access) begin
         s_d.slverr = 1'b0;
      end
      if (access && i_pwrite) begin
         if (i_paddr == `CM_ADDR_CTRL) begin
            s_d.mode_var = i_pwdata[`CM_CTRL_VAR_BIT];
            s_d.freq_high = i_pwdata[`CM_CTRL_HF_BIT];
            s_d.en = i_pwdata[`CM_CTRL_EN_BIT];
         end
         if (i_paddr == `CM_ADDR_PHASE && (s_q.mode_var || s_q.st != ST_LOCK)) begin
            s_d.phase = sat_phase(i_pwdata);
         end
      end

      // derived outputs from the next state, so pins match the tapped bits
      s_d.half = (s_d.st == ST_LOCK) & ~s_d.zero;
      s_d.quarter_out = s_d.quarter & ~s_d.freq_high;
      s_d.three_out = s_d.three & ~s_d.freq_high;
      s_d.dbl = (s_d.zero ^ s_d.quarter) & ~s_d.freq_high;
      s_d.dbl_inv = ~(s_d.zero ^ s_d.quarter) & ~s_d.freq_high & (s_d.st == ST_LOCK);
      s_d.fx_inv = (s_d.st == ST_LOCK) & ~s_d.fx;
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.phase <= `CM_PHASE_RESET;
         {s_q.en, s_q.freq_high, s_q.mode_var} <= `CM_CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign o_prdata = s_q.prdata;
   assign o_pready = s_q.ready;
   assign o_pslverr = s_q.slverr;
   assign o_zero_degree_output = s_q.zero;
   assign o_half_cycle_output = s_q.half;
   assign o_quarter_cycle_output = s_q.quarter_out;
   assign o_three_quarter_cycle_output = s_q.three_out;
   assign o_doubled_output = s_q.dbl;
   assign o_doubled_inverted_output = s_q.dbl_inv;
   assign o_divided_output = s_q.div;
   assign o_synthesized_output = s_q.fx;
   assign o_synthesized_inverted_output = s_q.fx_inv;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence apb_setup;
      i_psel && !i_penable;
   endsequence
   sequence apb_ctrl_write;
      apb_setup ##1 (i_psel && i_penable && i_pwrite && i_paddr == `CM_ADDR_CTRL);
   endsequence

   a_shift_product: assert property (!s_q.sat && $past(s_q.phase) == s_q.phase
      && $past(s_q.period) == s_q.period && $past(s_q.mode_var) == s_q.mode_var
      |-> s_q.shift == 10'((18'(s_q.phase) * 18'($signed({1'b0, s_q.period}))) >>> 8))
      else $error("shift does not follow phase times period");
   a_phase_range: assert property (s_q.phase <= 9'sd255 && s_q.phase >= -9'sd255)
      else $error("phase setting out of range");
   a_line_limit: assert property (s_q.shift <= 10'(SPAN) && s_q.shift >= -10'(SPAN))
      else $error("shift exceeds delay line");
   a_var_half: assert property ($past(s_q.mode_var) && s_q.mode_var
      |-> s_q.shift <= 10'(MID) && s_q.shift >= -10'(MID))
      else $error("variable shift exceeds half span");
   a_var_mid_tap: assert property ($past(s_q.mode_var) && s_q.mode_var
      |-> s_q.tap == 7'(MID + s_q.shift))
      else $error("variable tap not centred");
   a_fixed_hold: assert property (s_q.st == ST_LOCK && !s_q.mode_var
      ##1 s_q.st == ST_LOCK |-> $stable(s_q.phase))
      else $error("fixed phase changed while locked");
   a_hf_quiet: assert property (s_q.freq_high |-> !o_quarter_cycle_output
      && !o_three_quarter_cycle_output && !o_doubled_output
      && !o_doubled_inverted_output)
      else $error("quarter or doubled output active in high frequency");
   a_freq_select: assert property (apb_ctrl_write |=> s_q.freq_high == $past(i_pwdata[1]))
      else $error("frequency mode not taken from write");
   a_sat_edge: assert property (s_q.sat |-> s_q.shift == (s_q.mode_var ? 10'(MID) : 10'(SPAN))
      || s_q.shift == -(s_q.mode_var ? 10'(MID) : 10'(SPAN)))
      else $error("saturated shift not at limit");
   a_apb_answer: assert property (apb_setup |=> o_pready)
      else $error("no ready after setup");
endmodule // clock_manager_phase_shift

//--- hdl/clock_manager_pkg.sv
package clock_manager_pkg;
   // lock progress, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MEAS = 3'b010,
      ST_LOCK = 3'b100
   } lock_e;
endpackage

//--- verification/clock_manager_phase_shift_test.sv
`timescale 1ns/10ps
module clock_manager_phase_shift_test;
   logic i_clk, i_rst, i_psel, i_penable, i_pwrite, ref_q, fb_q, run;
   logic z, h, q, t, d, di, dv, s, si, o_pready, o_pslverr;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, lfsr_q;
   logic [64:0] expq[$];
   logic [64:0] e;
   logic signed [31:0] v;
   int errors, checks_done, half, cnt;
   int c[9];
   clock_manager_phase_shift dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_input_reference_clock(ref_q), .i_feedback_clock_input(fb_q),
      .o_zero_degree_output(z), .o_half_cycle_output(h), .o_quarter_cycle_output(q),
      .o_three_quarter_cycle_output(t), .o_doubled_output(d), .o_doubled_inverted_output(di),
      .o_divided_output(dv), .o_synthesized_output(s), .o_synthesized_inverted_output(si));
   // next value of the stimulus shift register
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // phase setting clamped to the accepted signed range
   function automatic logic [31:0] sat(input logic signed [31:0] x);
      return (x > 255) ? 32'h0000_00ff : (x < -255) ? 32'hffff_ff01 : x;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (expq.size() != 0) begin
         errors++;
      end
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one apb transfer; expectation noted before the request goes out
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic er, input logic [31:0] m, input logic [31:0] ed);
      expq.push_back({er, m, ed});
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      // pready only moves on rising edges, so its level at the falling edge
      // is the one sampled at the next rising edge
      @(negedge i_clk);
      while (o_pready !== 1'b1) begin
         @(negedge i_clk);
      end
      @(posedge i_clk);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 1'b0, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed);
      apb(1'b0, a, 32'h0, 1'b0, m, ed);
   endtask
   // count rising edges of the derived outputs over ten reference periods
   task automatic watch();
      logic [8:0] p, n;
      p = 9'h1ff;
      for (int k = 0; k < 9; k++) begin
         c[k] = 0;
      end
      repeat (160) begin
         @(posedge i_clk);
         #1;
         n = {si, s, dv, di, d, t, q, h, z};
         for (int k = 0; k < 9; k++) begin
            c[k] += int'(n[k] && !p[k]);
         end
         p = n;
      end
   endtask
   // answer watcher: compares each completed transfer with the oldest note
   always @(negedge i_clk) begin
      if (i_psel && i_penable && o_pready === 1'b1 && expq.size() > 0) begin
         e = expq.pop_front();
         chk({31'h0, o_pslverr}, {31'h0, e[64]});
         chk(o_prdata & e[63:32], e[31:0]);
      end
   end
   // reference clock with a programmable half period in system cycles
   always @(posedge i_clk) begin
      if (run && cnt >= half - 1) begin
         cnt <= 0;
         ref_q <= ~ref_q;
      end else if (run) begin
         cnt <= cnt + 1;
      end
   end
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      #800000;
      errors++;
      conclude();
   end
   initial begin
      {i_rst, i_psel, i_penable, i_pwrite, ref_q, fb_q, run} = 7'h40;
      {i_paddr, i_pwdata, cnt, half} = 0;
      lfsr_q = 32'hc313f214;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(8'h00, 32'hffff_ffff, 32'h0);
      rd(8'h04, 32'hffff_ffff, 32'h0);
      apb(1'b0, 8'h0c, 32'h0, 1'b1, 32'hffff_ffff, 32'h0);
      apb(1'b1, 8'h10, 32'h7, 1'b1, 32'h0, 32'h0);
      rd(8'h00, 32'hffff_ffff, 32'h0);
      $display("test 1 done");
      for (int i = 0; i < 12; i++) begin
         lfsr_q = nxt(lfsr_q);
         v = (i == 0) ? 256 : (i == 1) ? -256 : (i == 2) ? 255 : (i == 3) ? -255 :
             {{22{lfsr_q[9]}}, lfsr_q[9:0]};
         wr(8'h04, v);
         rd(8'h04, 32'hffff_ffff, sat(v));
      end
      $display("test 2 done");
      half = 8;
      run <= 1'b1;
      fb_q <= 1'b1;
      wr(8'h04, 32'd64);
      wr(8'h00, 32'h4);
      repeat (120) @(posedge i_clk);
      rd(8'h08, 32'h007f_ff07, 32'h0004_1005);
      wr(8'h04, 32'd10);
      rd(8'h04, 32'hffff_ffff, 32'd64);
      watch();
      chk(32'(c[0] >= 9 && c[0] <= 11), 32'h1);
      chk(32'(c[2] >= 9 && c[2] <= 11), 32'h1);
      chk(32'(c[6] >= 4 && c[6] <= 6), 32'h1);
      chk(32'(c[1] >= 9 && c[1] <= 11), 32'h1);
      chk(32'(c[3] >= 9 && c[3] <= 11), 32'h1);
      chk(32'(c[4] >= 18 && c[4] <= 22), 32'h1);
      chk(32'(c[5] >= 18 && c[5] <= 22), 32'h1);
      chk(32'(c[7] >= 1 && c[7] <= 2 && c[8] >= 1 && c[8] <= 2), 32'h1);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'hffff_ffc0);
      wr(8'h00, 32'h4);
      repeat (120) @(posedge i_clk);
      rd(8'h08, 32'h007f_ff07, 32'h000c_1005);
      $display("test 3 done");
      wr(8'h00, 32'h0);
      half = 100;
      wr(8'h04, 32'd60);
      wr(8'h00, 32'h4);
      repeat (600) @(posedge i_clk);
      rd(8'h08, 32'h007f_ff07, 32'h002e_c805);
      wr(8'h00, 32'h5);
      repeat (600) @(posedge i_clk);
      rd(8'h08, 32'h0000_0003, 32'h3);
      wr(8'h04, 32'hffff_fffd);
      rd(8'h04, 32'hffff_ffff, 32'hffff_fffd);
      repeat (20) @(posedge i_clk);
      rd(8'h08, 32'h0000_0003, 32'h1);
      $display("test 4 done");
      wr(8'h00, 32'h0);
      half = 8;
      wr(8'h00, 32'h6);
      repeat (120) @(posedge i_clk);
      watch();
      chk(32'(c[0] >= 9 && c[0] <= 11), 32'h1);
      chk(c[2] + c[3] + c[4] + c[5], 32'h0);
      chk(32'(c[1] >= 9 && c[1] <= 11 && c[6] >= 4 && c[6] <= 6), 32'h1);
      chk(32'(c[7] >= 1 && c[7] <= 2), 32'h1);
      $display("test 5 done");
      conclude();
   end
endmodule // clock_manager_phase_shift_test
